// file: rtl/periodic_timer_pkg.sv
// constants and types for the periodic timer
package periodic_timer_pkg;
  localparam int          CNT_W        = 10;
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  ADDR_CTRL0   = 3'h0;
  localparam logic [2:0]  ADDR_CTRL1   = 3'h1;
  localparam logic [2:0]  ADDR_CNT_LO  = 3'h2;
  localparam logic [2:0]  ADDR_CNT_HI  = 3'h3;
  localparam logic [2:0]  ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0]  ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0]  ADDR_CMPP_LO = 3'h6;
  localparam logic [2:0]  ADDR_CMPP_HI = 3'h7;
  localparam int          BIT_PAUSE    = 7;
  localparam int          BIT_CLK_HI   = 6;
  localparam int          BIT_CLK_LO   = 4;
  localparam int          BIT_RUN      = 3;
  localparam int          BIT_MODE_HI  = 7;
  localparam int          BIT_MODE_LO  = 6;
  localparam int          BIT_PIN_HI   = 5;
  localparam int          BIT_PIN_LO   = 4;
  localparam int          BIT_INIT     = 3;
  localparam int          BIT_INV      = 2;
  localparam int          BIT_CAPSRC   = 1;
  localparam int          BIT_CLRSEL   = 0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  CTRL0_MASK   = 8'hF8;
  localparam logic [1:0]  MODE_COMPARE = 2'h0;
  localparam logic [1:0]  MODE_CAPTURE = 2'h1;
  localparam logic [1:0]  MODE_PWM     = 2'h2;
  localparam logic [1:0]  MODE_TIMER   = 2'h3;
  localparam logic [1:0]  PIN_NONE     = 2'h0;
  localparam logic [1:0]  PIN_LOW      = 2'h1;
  localparam logic [1:0]  PIN_HIGH     = 2'h2;
  localparam logic [1:0]  PIN_TOGGLE   = 2'h3;
  localparam logic [1:0]  CAP_RISE     = 2'h0;
  localparam logic [1:0]  CAP_FALL     = 2'h1;
  localparam logic [1:0]  CAP_BOTH     = 2'h2;
  localparam logic [2:0]  CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0]  CLK_SYS      = 3'h1;
  localparam logic [2:0]  CLK_HS_DIV16 = 3'h2;
  localparam logic [2:0]  CLK_HS_DIV64 = 3'h3;
  localparam logic [2:0]  CLK_SUB_A    = 3'h4;
  localparam logic [2:0]  CLK_SUB_B    = 3'h5;
  localparam logic [2:0]  CLK_EXT_RISE = 3'h6;
  localparam logic [2:0]  CLK_EXT_FALL = 3'h7;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  localparam logic [5:0]  DIV16_LAST   = 6'h0F;
  localparam logic [5:0]  DIV64_LAST   = 6'h3F;
  localparam logic [9:0]  CNT_ZERO     = 10'h000;
  localparam logic [9:0]  CNT_MAX      = 10'h3FF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic       compare_a_flag;
    logic       compare_p_flag;
    logic       capture;
  } timer_event_t;
endpackage

// file: rtl/periodic_timer.sv
// 10-bit periodic timer with two comparators, output pin and capture
//
// Functional notes
// R1: 10-bit up counter advancing on selected ticks
// R2: comparators A and P match full 10 bits
// R3: counter cleared by run-enable rising
// R4: overflow or selected match clears, raises flag
// R5: pause holds counter, resumes from value
// R6: 3-bit field selects counter clock source
// R7: run-enable low stops counter, keeps value
// R8: run-enable rise loads output initial level
// R9: 2-bit field selects operating mode
// R10: software stops timer before mode change
// R11: compare mode A match: none/low/high/toggle
// R12: pwm mode: inactive/active/pwm/single pulse
// R13: capture edge: rise/fall/both/disabled
// R14: match action equal to level changes nothing
// R15: software changes pwm pin field when stopped
// R16: initial level bit sets pre-match/active level
// R17: invert bit inverts output pin
// R18: capture source: capture pin or clock pin
// R19: clear select: A match, else P/overflow
// R20: clear select ignored in pwm and capture
// R21: counter read-only, compare values read/write pairs
// R22: unused control bits read as zero
// R23: compare A zero overflows, no A flag; pwm and capture modes still raise the A flag at zero
// R24: clear select A suppresses P flag
// R25: timer mode like compare, pin undriven
// R26: pins synchronised and edge detected
`timescale 1ns/1ns
module periodic_timer
  import periodic_timer_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire reg_req_t          req_i,
  output logic [7:0]             rdata_o,
  input  wire logic              high_clk_tick_i,
  input  wire logic              sub_clk_tick_i,
  input  wire logic              external_clock_pin_i,
  input  wire logic              capture_input_pin_i,
  output logic                   timer_output_pin_o,
  output logic                   timer_output_pin_oe_o,
  output logic                   compare_a_flag_o,
  output logic                   compare_p_flag_o,
  output logic                   capture_event_o,
  output logic [WIDTH-1:0]       capture_value_o
);

  typedef enum {PULSE_IDLE, PULSE_ACTIVE, PULSE_DONE} pulse_state_t;

  logic [7:0]       control_0;
  logic [7:0]       control_1;
  logic [WIDTH-1:0] counter;
  logic [WIDTH-1:0] compare_a_value;
  logic [WIDTH-1:0] compare_p_value;
  logic             run_q;
  logic             out_level;
  logic [1:0]       div4;
  logic [5:0]       div16;
  logic [5:0]       div64;
  logic [1:0]       ext_sync;
  logic [1:0]       cap_sync;
  logic             ext_prev;
  logic             cap_prev;
  pulse_state_t     pulse_state;

  logic             run_en;
  logic             pause;
  logic [2:0]       clk_sel;
  logic [1:0]       mode;
  logic [1:0]       pin_func;
  logic             init_level;
  logic             invert;
  logic             run_rise;
  logic             tick;
  logic             match_a;
  logic             match_p;
  logic             overflow;
  logic             clear_cnt;
  logic             flag_a;
  logic             flag_p;
  logic             cap_pin;
  logic             cap_prev_sel;
  logic             cap_hit;
  logic             next_out;
  logic [WIDTH-1:0] next_counter;

  function automatic logic [WIDTH-1:0] merge_low(input logic [WIDTH-1:0] v,
                                                 input logic [7:0] d);
    merge_low = {v[WIDTH-1:8], d};
  endfunction

  function automatic logic [WIDTH-1:0] merge_high(input logic [WIDTH-1:0] v,
                                                  input logic [7:0] d);
    merge_high = {d[WIDTH-9:0], v[7:0]};
  endfunction

  function automatic logic [7:0] high_part(input logic [WIDTH-1:0] v);
    high_part = {{(16-WIDTH){1'b0}}, v[WIDTH-1:8]};
  endfunction

  assign pause      = control_0[BIT_PAUSE];
  assign clk_sel    = control_0[BIT_CLK_HI:BIT_CLK_LO];
  assign run_en     = control_0[BIT_RUN];
  assign mode       = control_1[BIT_MODE_HI:BIT_MODE_LO];                // see R9
  assign pin_func   = control_1[BIT_PIN_HI:BIT_PIN_LO];
  assign init_level = control_1[BIT_INIT];
  assign invert     = control_1[BIT_INV];
  assign run_rise   = run_en && !run_q;

  // registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      control_0       <= CTRL_RESET;
      control_1       <= CTRL_RESET;
      compare_a_value <= '0;
      compare_p_value <= '0;
    end else if (req_i.wr) begin
      case (req_i.addr)
        ADDR_CTRL0:   control_0 <= req_i.wdata & CTRL0_MASK;               // see R22
        ADDR_CTRL1:   control_1 <= req_i.wdata;
        ADDR_CMPA_LO: compare_a_value <= merge_low(compare_a_value, req_i.wdata);  // see R21
        ADDR_CMPA_HI: compare_a_value <= merge_high(compare_a_value, req_i.wdata);
        ADDR_CMPP_LO: compare_p_value <= merge_low(compare_p_value, req_i.wdata);
        ADDR_CMPP_HI: compare_p_value <= merge_high(compare_p_value, req_i.wdata);
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe; counter bytes are read only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        ADDR_CTRL0:   rdata_o <= control_0 & CTRL0_MASK;                   // see R22
        ADDR_CTRL1:   rdata_o <= control_1;
        ADDR_CNT_LO:  rdata_o <= counter[7:0];                             // see R21
        ADDR_CNT_HI:  rdata_o <= high_part(counter);
        ADDR_CMPA_LO: rdata_o <= compare_a_value[7:0];
        ADDR_CMPA_HI: rdata_o <= high_part(compare_a_value);
        ADDR_CMPP_LO: rdata_o <= compare_p_value[7:0];
        ADDR_CMPP_HI: rdata_o <= high_part(compare_p_value);
        default:      rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // prescalers stop while the timer is off to save power
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_en) begin
      div4  <= '0;
      div16 <= '0;
      div64 <= '0;
    end else begin
      div4 <= div4 + 2'h1;
      if (high_clk_tick_i) begin
        div16 <= (div16 == DIV16_LAST) ? 6'h00 : div16 + 6'h01;
        div64 <= (div64 == DIV64_LAST) ? 6'h00 : div64 + 6'h01;
      end
    end
  end

  // two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ext_sync <= 2'h0;
      cap_sync <= 2'h0;
      ext_prev <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], external_clock_pin_i};                    // see R26
      cap_sync <= {cap_sync[0], capture_input_pin_i};
      ext_prev <= ext_sync[1];
      cap_prev <= cap_sync[1];
    end
  end

  always_comb begin
    case (clk_sel)                                                         // see R6
      CLK_SYS_DIV4: tick = (div4 == DIV4_LAST);
      CLK_SYS:      tick = 1'b1;
      CLK_HS_DIV16: tick = high_clk_tick_i && (div16 == DIV16_LAST);
      CLK_HS_DIV64: tick = high_clk_tick_i && (div64 == DIV64_LAST);
      CLK_SUB_A,
      CLK_SUB_B:    tick = sub_clk_tick_i;
      CLK_EXT_RISE: tick = ext_sync[1] && !ext_prev;                       // see R26
      CLK_EXT_FALL: tick = !ext_sync[1] && ext_prev;
      default:      tick = 1'b0;
    endcase
  end

  // comparators look at every counter bit
  assign match_a  = tick && (counter == compare_a_value);                  // see R2
  assign match_p  = tick && (counter == compare_p_value);
  assign overflow = tick && (counter == CNT_MAX);

  always_comb begin
    clear_cnt = 1'b0;
    flag_a    = 1'b0;
    flag_p    = 1'b0;
    if (mode == MODE_COMPARE || mode == MODE_TIMER) begin                  // see R25
      if (control_1[BIT_CLRSEL]) begin                                     // see R19
        // A value zero leaves only the overflow to clear
        flag_a    = match_a && (compare_a_value != CNT_ZERO);              // see R23
        clear_cnt = flag_a || overflow;                                    // see R4
        flag_p    = 1'b0;                                                  // see R24
      end else begin
        flag_a    = match_a && (compare_a_value != CNT_ZERO);
        flag_p    = (compare_p_value == CNT_ZERO) ? overflow : match_p;
        clear_cnt = flag_p || overflow;
      end
    end else begin
      // clear select is not looked at in these modes
      flag_a    = match_a;                                                 // see R20
      flag_p    = (compare_p_value == CNT_ZERO) ? overflow : match_p;
      clear_cnt = (mode == MODE_PWM) ? flag_p : overflow;
    end
  end

  always_comb begin
    if (!run_en || pause) begin
      next_counter = counter;                                              // see R5
    end else if (clear_cnt) begin
      next_counter = '0;                                                   // see R4
    end else if (tick) begin
      next_counter = counter + 1'b1;                                       // see R1
    end else begin
      next_counter = counter;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      counter <= '0;
      run_q   <= 1'b0;
    end else begin
      run_q <= run_en;
      if (run_rise) begin
        counter <= '0;                                                     // see R3
      end else begin
        counter <= next_counter;                                           // see R7
      end
    end
  end

  logic ev_a;
  logic ev_p;
  assign ev_a = flag_a && run_en && !pause && !run_rise;
  assign ev_p = flag_p && run_en && !pause && !run_rise;

  // capture trigger
  assign cap_pin      = control_1[BIT_CAPSRC] ? ext_sync[1] : cap_sync[1];  // see R18
  assign cap_prev_sel = control_1[BIT_CAPSRC] ? ext_prev : cap_prev;
  always_comb begin
    case (pin_func)                                                        // see R13
      CAP_RISE: cap_hit = cap_pin && !cap_prev_sel;
      CAP_FALL: cap_hit = !cap_pin && cap_prev_sel;
      CAP_BOTH: cap_hit = cap_pin != cap_prev_sel;
      default:  cap_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      compare_a_flag_o <= 1'b0;
      compare_p_flag_o <= 1'b0;
      capture_event_o  <= 1'b0;
      capture_value_o  <= '0;
    end else begin
      compare_a_flag_o <= ev_a;
      compare_p_flag_o <= ev_p;
      capture_event_o  <= 1'b0;
      if (mode == MODE_CAPTURE && run_en && cap_hit) begin
        capture_event_o <= 1'b1;
        capture_value_o <= counter;
      end
    end
  end

  // output level before inversion
  always_comb begin
    next_out = out_level;
    if (run_rise) begin
      next_out = init_level;                                               // see R8
    end else if (mode == MODE_COMPARE && ev_a) begin
      case (pin_func)                                                      // see R11
        PIN_LOW:    next_out = 1'b0;                                       // see R14
        PIN_HIGH:   next_out = 1'b1;
        PIN_TOGGLE: next_out = !out_level;
        default:    next_out = out_level;
      endcase
    end else if (mode == MODE_PWM) begin
      // pwm duty ends at the A match; period restarts at clear
      case (pin_func)                                                      // see R12
        PIN_NONE: next_out = !init_level;                                  // see R16
        PIN_LOW:  next_out = init_level;
        PIN_HIGH: begin
          if (ev_a) begin
            next_out = !init_level;
          end else if (ev_p || (run_en && !pause && tick && counter == CNT_ZERO)) begin
            next_out = (compare_a_value != CNT_ZERO) ? init_level : !init_level;
          end
        end
        default: begin
          if (pulse_state == PULSE_ACTIVE && ev_a) begin
            next_out = !init_level;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_level   <= 1'b0;
      pulse_state <= PULSE_IDLE;
    end else begin
      out_level <= next_out;
      case (pulse_state)
        PULSE_IDLE:   if (run_rise) begin
          pulse_state <= PULSE_ACTIVE;
        end
        PULSE_ACTIVE: if (ev_a || !run_en) begin
          pulse_state <= PULSE_DONE;
        end
        PULSE_DONE:   if (run_rise) begin
          pulse_state <= PULSE_ACTIVE;
        end
        default:      pulse_state <= PULSE_IDLE;
      endcase
    end
  end

  // pin drive: not driven in capture or timer mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_output_pin_o    <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end else begin
      timer_output_pin_o    <= next_out ^ invert;                          // see R17
      timer_output_pin_oe_o <= (mode == MODE_COMPARE) || (mode == MODE_PWM);  // see R25
    end
  end

  a_run_clears_count: assert property (@(posedge clock_i) disable iff (rst_i) // see R3
    $rose(run_en) |=> counter == CNT_ZERO)
    else $error("counter not cleared on run enable");
  a_pause_holds: assert property (@(posedge clock_i) disable iff (rst_i) // see R5
    (pause && run_q && run_en) |=> $stable(counter))
    else $error("counter moved while paused");
  a_off_holds: assert property (@(posedge clock_i) disable iff (rst_i) // see R7
    (!run_en && !$past(run_en)) |=> $stable(counter))
    else $error("counter moved while off");
  a_init_level: assert property (@(posedge clock_i) disable iff (rst_i) // see R8
    run_rise |=> out_level == $past(init_level))
    else $error("output not at initial level");
  a_no_p_flag: assert property (@(posedge clock_i) disable iff (rst_i) // see R24
    (control_1[BIT_CLRSEL] && mode == MODE_COMPARE) |=> !compare_p_flag_o)
    else $error("p flag with clear select a");
  a_a_zero_flag: assert property (@(posedge clock_i) disable iff (rst_i) // see R23
    (mode == MODE_COMPARE && compare_a_value == CNT_ZERO) |=> !compare_a_flag_o)
    else $error("a flag with zero compare");
  a_invert_pin: assert property (@(posedge clock_i) disable iff (rst_i) // see R17
    run_rise |=> timer_output_pin_o == ($past(init_level) ^ $past(invert)))
    else $error("pin polarity wrong");
  a_clear_on_match: assert property (@(posedge clock_i) disable iff (rst_i) // see R19
    (ev_a && control_1[BIT_CLRSEL] && mode == MODE_COMPARE) |=> counter == CNT_ZERO)
    else $error("counter not cleared on a match");
  a_pin_undriven: assert property (@(posedge clock_i) disable iff (rst_i) // see R25
    (mode == MODE_TIMER) [*2] |-> !timer_output_pin_oe_o)
    else $error("pin driven in timer mode");

  c_a_match: cover property (@(posedge clock_i) compare_a_flag_o);
  c_p_match: cover property (@(posedge clock_i) compare_p_flag_o);
  c_capture: cover property (@(posedge clock_i) capture_event_o);
  c_toggle:  cover property (@(posedge clock_i) mode == MODE_COMPARE && $changed(out_level));

endmodule // periodic_timer

// file: tb/pin_model.sv
// model of the far side: external clock pin and capture pin
`timescale 1ns/1ns
module pin_model (
  input  wire logic clock_i,
  output logic      ext_pin_o,
  output logic      cap_pin_o
);
  // both pins idle low between bursts; nothing runs free
  initial begin
    ext_pin_o = 1'h0;
    cap_pin_o = 1'h0;
  end

  // each level is held four cycles so the two-stage synchroniser sees it
  task automatic pulse(input bit on_ext, input int n);
    repeat (2 * n) begin
      @(posedge clock_i);
      if (on_ext) ext_pin_o <= ~ext_pin_o;
      else cap_pin_o <= ~cap_pin_o;
      repeat (3) @(posedge clock_i);
    end
  endtask
endmodule // pin_model

// file: tb/periodic_timer_bench.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ns
module periodic_timer_bench
  import periodic_timer_pkg::*;
;
  typedef struct {
    logic [2:0] sel;
    int         n;
    int         exp;
    int         tol;
  } clk_row_t;

  logic             clock_i;
  logic             rst_i;
  reg_req_t         req;
  logic [7:0]       rdata;
  logic             hs_tick;
  logic             sub_tick;
  logic             ext_pin;
  logic             cap_pin;
  logic             pin;
  logic             pin_oe;
  logic             fa;
  logic             fp;
  logic             cap_ev;
  logic [CNT_W-1:0] cap_val;
  logic [7:0]       d;
  logic [9:0]       c1;
  logic [9:0]       c2;
  int               failures;
  int               checks;
  int               na;
  int               np;
  int               nc;
  // system and high-speed sources allow one count of slack for prescaler phase
  clk_row_t         rows [8] = '{'{CLK_SYS_DIV4, 38, 10, 1}, '{CLK_SYS, 38, 40, 1},
                                 '{CLK_HS_DIV16, 32, 2, 1}, '{CLK_HS_DIV64, 128, 2, 1},
                                 '{CLK_SUB_A, 3, 3, 0}, '{CLK_SUB_B, 4, 4, 0},
                                 '{CLK_EXT_RISE, 5, 5, 0}, '{CLK_EXT_FALL, 6, 6, 0}};
  logic [7:0]       fill [8] = '{8'hF8, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03};

  periodic_timer dut_u (
    .clock_i               (clock_i),
    .rst_i                 (rst_i),
    .req_i                 (req),
    .rdata_o               (rdata),
    .high_clk_tick_i       (hs_tick),
    .sub_clk_tick_i        (sub_tick),
    .external_clock_pin_i  (ext_pin),
    .capture_input_pin_i   (cap_pin),
    .timer_output_pin_o    (pin),
    .timer_output_pin_oe_o (pin_oe),
    .compare_a_flag_o      (fa),
    .compare_p_flag_o      (fp),
    .capture_event_o       (cap_ev),
    .capture_value_o       (cap_val)
  );

  pin_model pm_u (
    .clock_i   (clock_i),
    .ext_pin_o (ext_pin),
    .cap_pin_o (cap_pin)
  );

  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  // event pulses last one cycle, so they are counted mid-cycle
  always @(negedge clock_i) begin
    na += (fa === 1'h1);
    np += (fp === 1'h1);
    nc += (cap_ev === 1'h1);
  end

  task automatic conclude();
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic near(input logic [9:0] s, input int lo, input int hi);
    check({9'h000, s >= lo && s <= hi}, 10'h001);
  endtask

  // a gap cycle after each strobe keeps every signal to one update per step
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
    @(posedge clock_i);
    req <= '0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clock_i);
    req <= '0;
    @(negedge clock_i);
    v = rdata;
    @(posedge clock_i);
  endtask

  // only safe while the counter stands still: the bytes are not latched together
  task automatic rdcnt(output logic [9:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(ADDR_CNT_LO, lo);
    rd(ADDR_CNT_HI, hi);
    c = {hi[1:0], lo};
  endtask

  task automatic window(input int n);
    na = 0;
    np = 0;
    nc = 0;
    repeat (n) @(posedge clock_i);
  endtask

  task automatic tick(input bit sub, input int n);
    repeat (n) begin
      if (sub) sub_tick <= 1'h1;
      else hs_tick <= 1'h1;
      @(posedge clock_i);
      sub_tick <= 1'h0;
      hs_tick <= 1'h0;
      @(posedge clock_i);
    end
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    failures++;
    conclude();
  end

  initial begin
    rst_i = 1'h1;
    req = '0;
    hs_tick = 1'h0;
    sub_tick = 1'h0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i);
    foreach (rows[i]) begin
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL0, {1'h1, rows[i].sel, 4'h8});
      wr(ADDR_CTRL0, {1'h0, rows[i].sel, 4'h8});
      case (rows[i].sel)
        CLK_SYS_DIV4, CLK_SYS: repeat (rows[i].n) @(posedge clock_i);
        CLK_EXT_RISE, CLK_EXT_FALL: begin
          pm_u.pulse(1'h1, rows[i].n);
          repeat (4) @(posedge clock_i);
        end
        default: tick(rows[i].sel >= CLK_SUB_A, rows[i].n);
      endcase
      wr(ADDR_CTRL0, {1'h1, rows[i].sel, 4'h8});
      rdcnt(c1);
      near(c1, rows[i].exp - rows[i].tol, rows[i].exp + rows[i].tol);
    end
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CTRL0, 8'h18);
    repeat (6) @(posedge clock_i);
    wr(ADDR_CTRL0, 8'h10);
    rdcnt(c1);
    repeat (20) @(posedge clock_i);
    wr(ADDR_CNT_LO, 8'hFF);
    wr(ADDR_CNT_HI, 8'h03);
    rdcnt(c2);
    check(c2, c1);
    near(c1, 5, 9);
    wr(ADDR_CTRL0, 8'h98);
    rdcnt(c1);
    check(c1, 10'h000);
    wr(ADDR_CTRL0, 8'h18);
    repeat (8) @(posedge clock_i);
    wr(ADDR_CTRL0, 8'h98);
    rdcnt(c1);
    repeat (20) @(posedge clock_i);
    rdcnt(c2);
    check(c2, c1);
    wr(ADDR_CTRL0, 8'h18);
    repeat (8) @(posedge clock_i);
    wr(ADDR_CTRL0, 8'h98);
    rdcnt(c2);
    near(c2 - c1, 9, 11);
    wr(ADDR_CMPA_LO, 8'h05);
    wr(ADDR_CMPP_LO, 8'h0A);
    for (int f = 0; f < 4; f++) begin
      for (int v = 0; v < 4; v++) begin
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, {MODE_COMPARE, f[1:0], v[0], v[1], 2'h0});
        wr(ADDR_CTRL0, 8'h18);
        @(negedge clock_i);
        check(pin, v[0] ^ v[1]);
        window(8);
        @(negedge clock_i);
        check(pin, (f == 0 ? v[0] : f == 3 ? !v[0] : f == 2) ^ v[1]);
        check(10'(na), 10'h001);
        check(pin_oe, 1'h1);
        @(posedge clock_i);
      end
    end
    window(110);
    near(10'(na), 9, 11);
    near(10'(np), 9, 11);
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CMPP_LO, 8'h03);
    wr(ADDR_CTRL1, 8'h01);
    wr(ADDR_CTRL0, 8'h18);
    window(60);
    near(10'(na), 9, 11);
    check(10'(np), 10'h000);
    wr(ADDR_CMPA_LO, 8'h00);
    repeat (3) @(posedge clock_i);
    window(60);
    check(10'(na + np), 10'h000);
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CMPA_LO, 8'h05);
    wr(ADDR_CMPP_LO, 8'h0A);
    wr(ADDR_CTRL1, {MODE_TIMER, 6'h00});
    wr(ADDR_CTRL0, 8'h18);
    window(110);
    near(10'(na), 9, 11);
    near(10'(np), 9, 11);
    check(pin_oe, 1'h0);
    // run rise shows the initial level first; the pin function takes over a cycle later
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL1, {MODE_PWM, f[1:0], 4'h8});
      wr(ADDR_CTRL0, 8'h18);
      @(negedge clock_i);
      check(pin, 10'h001);
      @(negedge clock_i);
      check(pin, f != 0);
      window(8);
      @(negedge clock_i);
      check(pin, f == 1);
      repeat (2) @(negedge clock_i);
      check(pin, f == 1 || f == 2);
      @(posedge clock_i);
    end
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 2; s++) begin
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, {MODE_CAPTURE, e[1:0], 2'h0, s[0], 1'h0});
        wr(ADDR_CTRL0, 8'h18);
        window(2);
        pm_u.pulse(s[0], 1);
        pm_u.pulse(!s[0], 1);
        repeat (4) @(posedge clock_i);
        check(10'(nc), e == 3 ? 10'h000 : e == 2 ? 10'h002 : 10'h001);
        if (e != 3) check(cap_val, e == 0 ? 10'h005 : 10'h009);
      end
    end
    // reset in mid-run, then every register from the top down so ctrl1 changes while stopped
    rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i);
    for (int a = 7; a >= 0; a--) begin
      rd(a[2:0], d);
      check(d, 8'h00);
      wr(a[2:0], 8'hFF);
      rd(a[2:0], d);
      check(d, fill[a]);
    end
    conclude();
  end
endmodule // periodic_timer_bench
